// >>> src/adcrat_top.sv
// adcrat_top: result registers, control registers and auto-trigger logic
// of a 10-bit converter, reached over AXI4-Lite.
// assumes the analog converter and the event flags run on clk.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - completed conversion loads the result pair
// - low read locks result until high read
// - left align bit selects result layout
// - right aligned: high holds 9..8
// - left aligned: high holds 9..2
// - control b bit 7 selects bipolar
// - unipolar reversed inputs saturate to full scale
// - bipolar result is two's complement
// - unipolar result is ten unsigned bits
// - trigger field only acts when enabled
// - rising edge of chosen flag starts conversion
// - source switch clear-to-set acts as edge
// - switching to free running never triggers
// - trigger field selects one of seven flags, zero is free running
// - complete flag set on finish, cleared
// - auto trigger enable arms edge starts
module adcrat_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [adcrat_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [adcrat_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [adcrat_pkg::RES_W-1:0] conv_data,
    input wire logic conv_pos_above_neg,
    input wire logic [adcrat_pkg::NFLAG-1:1] trig_flags,
    input wire logic int_ack,
    output logic converter_enable,
    output logic bipolar_select,
    output logic [4:0] channel_select_bits,
    output logic irq
);
    import adcrat_pkg::*;

    typedef struct packed {
        adcrat_conv_type state;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [7:0] wdata;
        logic w_lane;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [RES_W-1:0] result;
        logic locked;
        logic en;
        logic ate;
        logic flag;
        logic overrun;
        logic bipolar;
        logic [2:0] cb_misc;
        logic [2:0] trig_src;
        logic left_align;
        logic [4:0] chan;
        logic [1:0] mask;
        logic irq;
        logic conv_start;
    } adcrat_state_type;

    adcrat_state_type s_reg, s_next;

    logic wr_fire, wr_ok, rd_take, rd_low, rd_high;
    logic done_ok, upd, busy_after, free_run, sw_start, en_eff, start_req;
    logic wr_ctrl_a, trig_edge;
    logic [RES_W-1:0] cap_val;
    logic [7:0] hi_byte, lo_byte;
    logic [NFLAG-1:0] all_flags;
    logic [7:0] rd_byte;
    logic rd_map;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    adcrat_align u_align (
        .result(s_reg.result),
        .left_align(s_reg.left_align),
        .hi_byte(hi_byte),
        .lo_byte(lo_byte)
    );

    // flag zero is the complete flag, 1..7 the outside events
    assign all_flags = {trig_flags, s_reg.flag};

    adcrat_trig u_trig (
        .clk(clk),
        .sys_rst(sys_rst),
        .flags(all_flags),
        .src(s_reg.trig_src),
        .ate(s_reg.ate),
        .trig_edge(trig_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode of bus and converter events

    // write fires in the cycle in which both address and data are held
    assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    assign wr_ok = s_reg.aw_addr inside {OFF_RES_LO, OFF_RES_HI, OFF_CTRL_A,
        OFF_CTRL_B, OFF_INSEL, OFF_IRQ_ST, OFF_IRQ_MSK};
    assign wr_ctrl_a = wr_fire && s_reg.w_lane && s_reg.aw_addr == OFF_CTRL_A;
    assign rd_take = s_axi_arvalid && s_reg.arready;
    assign rd_low = rd_take && s_axi_araddr == OFF_RES_LO;
    assign rd_high = rd_take && s_axi_araddr == OFF_RES_HI;

    assign done_ok = conv_done && s_reg.state == ST_BUSY;
    // a locked pair drops the new result
    assign upd = done_ok && !s_reg.locked;
    assign cap_val = adcrat_capture(conv_data, s_reg.bipolar, conv_pos_above_neg);

    assign busy_after = s_reg.state == ST_BUSY && !conv_done;
    assign free_run = s_reg.ate && s_reg.trig_src == TRIG_FREE;
    assign sw_start = wr_ctrl_a && s_reg.wdata[CA_START];
    // enabling and starting in one write is allowed
    assign en_eff = wr_ctrl_a ? s_reg.wdata[CA_EN] : s_reg.en;
    // edge starts only with converter enabled
    assign start_req = en_eff && !busy_after
        && (sw_start || trig_edge || (free_run && done_ok));

    // read data mux; prescaler bits are not held here and read zero
    always_comb begin
        rd_map = 1'b1;
        case (s_axi_araddr)
            OFF_RES_LO: rd_byte = lo_byte;
            OFF_RES_HI: rd_byte = hi_byte;
            OFF_CTRL_A: rd_byte = {s_reg.en, s_reg.state == ST_BUSY, s_reg.ate,
                s_reg.flag, s_reg.mask[IRQ_DONE], 3'h0};
            OFF_CTRL_B: rd_byte = {s_reg.bipolar, s_reg.cb_misc, 1'b0, s_reg.trig_src};
            OFF_INSEL: rd_byte = {2'h0, s_reg.left_align, s_reg.chan};
            OFF_IRQ_ST: rd_byte = {6'h00, s_reg.overrun, s_reg.flag};
            OFF_IRQ_MSK: rd_byte = {6'h00, s_reg.mask};
            default: begin
                rd_byte = 8'h00;
                rd_map = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next = s_reg;
        s_next.conv_start = 1'b0;

        // write address and data are taken in either order
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata[7:0];
            s_next.w_lane = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // read answer follows the address by one edge
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (rd_take) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = {24'h000000, rd_byte};
            s_next.rresp = rd_map ? RESP_OKAY : RESP_SLVERR;
        end

        // register writes; lane 0 carries every field
        if (wr_fire && s_reg.w_lane) begin
            case (s_reg.aw_addr)
                OFF_CTRL_A: begin
                    s_next.en = s_reg.wdata[CA_EN];
                    s_next.ate = s_reg.wdata[CA_ATE];
                    s_next.mask[IRQ_DONE] = s_reg.wdata[CA_IE];
                    if (s_reg.wdata[CA_FLAG]) begin
                        s_next.flag = 1'b0;
                    end
                end
                OFF_CTRL_B: begin
                    s_next.bipolar = s_reg.wdata[CB_BIN];
                    s_next.cb_misc = s_reg.wdata[CB_MISC_LSB +: 3];
                    // reserved bit is not stored, reads zero
                    s_next.trig_src = s_reg.wdata[CB_TRIG_LSB +: 3];
                end
                OFF_INSEL: begin
                    s_next.left_align = s_reg.wdata[IS_LEFT];
                    s_next.chan = s_reg.wdata[IS_CHAN_LSB +: 5];
                end
                OFF_IRQ_ST: begin
                    if (s_reg.wdata[IRQ_DONE]) begin
                        s_next.flag = 1'b0;
                    end
                    if (s_reg.wdata[IRQ_OVR]) begin
                        s_next.overrun = 1'b0;
                    end
                end
                OFF_IRQ_MSK: begin
                    s_next.mask = s_reg.wdata[1:0];
                end
                default: begin
                    s_next.mask = s_reg.mask;
                end
            endcase
        end

        // vector service clears the complete flag
        if (int_ack) begin
            s_next.flag = 1'b0;
        end

        // low read locks, high read unlocks
        // relies on software reading low first
        if (rd_low) begin
            s_next.locked = 1'b1;
        end else if (rd_high) begin
            s_next.locked = 1'b0;
        end

        // converter sequencing; clearing enable aborts a conversion
        case (s_reg.state)
            ST_IDLE: begin
                s_next.state = ST_IDLE;
            end
            ST_BUSY: begin
                if (conv_done || !en_eff) begin
                    s_next.state = ST_IDLE;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
        if (start_req) begin
            s_next.state = ST_BUSY;
            s_next.conv_start = 1'b1;
        end

        // result load on completion; sets win over clears
        if (done_ok) begin
            s_next.flag = 1'b1;
            if (upd) begin
                s_next.result = cap_val;
            end else begin
                s_next.overrun = 1'b1;
            end
        end

        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
        s_next.irq = |({s_next.overrun, s_next.flag} & s_next.mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from the state register

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign conv_start = s_reg.conv_start;
    assign converter_enable = s_reg.en;
    assign bipolar_select = s_reg.bipolar;
    assign channel_select_bits = s_reg.chan;
    assign irq = s_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_done_free;
        done_ok && free_run && s_reg.en && !(wr_ctrl_a && !s_reg.wdata[CA_EN]);
    endsequence

    sequence s_restart;
        conv_start && s_reg.state == ST_BUSY;
    endsequence

    // completions may arrive while locked; only the high read may unlock
    sequence s_low_then_idle;
        rd_low ##1 (!rd_high)[*2];
    endsequence

    result_load_a: assert property (upd |=> s_reg.result == $past(cap_val))
        else $error("result not loaded on completion");

    lock_hold_a: assert property (s_low_then_idle |-> $stable(s_reg.result))
        else $error("locked result changed");

    lock_drop_a: assert property (s_reg.locked && done_ok |=> s_reg.overrun
        && $stable(s_reg.result))
        else $error("locked pair was updated");

    right_align_a: assert property (!s_reg.left_align |-> hi_byte[7:2] == 6'h00
        && {hi_byte[1:0], lo_byte} == s_reg.result)
        else $error("right aligned layout wrong");

    left_align_a: assert property (s_reg.left_align |-> lo_byte[5:0] == 6'h00
        && {hi_byte, lo_byte[7:6]} == s_reg.result)
        else $error("left aligned layout wrong");

    sat_a: assert property (upd && !s_reg.bipolar && !conv_pos_above_neg
        |=> s_reg.result == RES_SAT)
        else $error("unipolar result not saturated");

    bipolar_a: assert property (upd && s_reg.bipolar
        |=> s_reg.result == $past(conv_data))
        else $error("bipolar code altered");

    gate_a: assert property (!s_reg.ate |-> !trig_edge)
        else $error("trigger edge while auto trigger off");

    edge_start_a: assert property (trig_edge && s_reg.en && !wr_ctrl_a
        && !busy_after |=> conv_start ##1 !conv_start)
        else $error("edge did not start one conversion");

    free_quiet_a: assert property (s_reg.trig_src != TRIG_FREE
        && s_next.trig_src == TRIG_FREE |=> !trig_edge)
        else $error("switch to free running triggered");

    flag_set_a: assert property (done_ok |=> s_reg.flag)
        else $error("complete flag not set");

    free_run_a: assert property (s_done_free |=> s_restart)
        else $error("free running did not restart");

    irq_level_a: assert property ((s_reg.flag && s_reg.mask[IRQ_DONE]) && !int_ack
        && !wr_fire |=> irq)
        else $error("unmasked flag gave no interrupt");

    read_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
endmodule // adcrat_top
`default_nettype wire

// >>> src/adcrat_pkg.sv
// adcrat_pkg: register map, field positions and codes for the converter
// result and auto-trigger block; shared by the top and its two helpers.
package adcrat_pkg;
    localparam int ADDR_W = 8;
    localparam int RES_W = 10;
    localparam int NFLAG = 8;

    // byte offsets of the register words
    localparam logic [7:0] OFF_RES_LO = 8'h00;
    localparam logic [7:0] OFF_RES_HI = 8'h04;
    localparam logic [7:0] OFF_CTRL_A = 8'h08;
    localparam logic [7:0] OFF_CTRL_B = 8'h0C;
    localparam logic [7:0] OFF_INSEL = 8'h10;
    localparam logic [7:0] OFF_IRQ_ST = 8'h14;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h18;

    // converter_control_a fields
    localparam int CA_EN = 7;
    localparam int CA_START = 6;
    localparam int CA_ATE = 5;
    localparam int CA_FLAG = 4;
    localparam int CA_IE = 3;
    // converter_control_b fields
    localparam int CB_BIN = 7;
    localparam int CB_MISC_LSB = 4;
    localparam int CB_TRIG_LSB = 0;
    // input_select_register fields
    localparam int IS_LEFT = 5;
    localparam int IS_CHAN_LSB = 0;
    // interrupt status / mask bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVR = 1;

    localparam logic [2:0] TRIG_FREE = 3'h0;
    localparam logic [RES_W-1:0] RES_SAT = 10'h3FF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {ST_IDLE, ST_BUSY} adcrat_conv_type;

    // unipolar results clamp to full scale when the inputs are reversed
    function automatic logic [RES_W-1:0] adcrat_capture(
        input logic [RES_W-1:0] raw, input logic bipolar, input logic pos_above);
        if (!bipolar && !pos_above) begin
            return RES_SAT;
        end
        return raw;
    endfunction
endpackage

// >>> src/adcrat_align.sv
// adcrat_align: splits the stored result into the two readable bytes.
// assumes a stable 10-bit result; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module adcrat_align (
    input wire logic [adcrat_pkg::RES_W-1:0] result,
    input wire logic left_align,
    output logic [7:0] hi_byte,
    output logic [7:0] lo_byte
);
    import adcrat_pkg::*;

    always_comb begin
        if (left_align) begin
            // bits 9..2 high, 1..0 on top of low
            hi_byte = result[9:2];
            lo_byte = {result[1:0], 6'h00};
        end else begin
            // bits 9..8 low in high byte
            hi_byte = {6'h00, result[9:8]};
            lo_byte = result[7:0];
        end
    end
endmodule // adcrat_align
`default_nettype wire

// >>> src/adcrat_trig.sv
// adcrat_trig: rising-edge detector on the selected interrupt flag.
// assumes the flags come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adcrat_trig (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [adcrat_pkg::NFLAG-1:0] flags,
    input wire logic [2:0] src,
    input wire logic ate,
    output logic trig_edge
);
    import adcrat_pkg::*;

    typedef struct packed {
        logic prev_level;
    } adcrat_trig_type;

    adcrat_trig_type s_reg, s_next;
    logic level;

    assign level = flags[src];

    // previous level comes from the old source, so a source switch can edge
    always_comb begin
        s_next = s_reg;
        s_next.prev_level = level;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // source switch edges, never free run
    assign trig_edge = ate && (src != TRIG_FREE) && level && !s_reg.prev_level;
endmodule // adcrat_trig
`default_nettype wire

// >>> tb/adcrat_tb.sv
// testbench for adcrat_top: register bus tasks plus directed tests of the
// result pair, alignment, lock, coding, interrupt and auto-trigger logic.
// assumes the bench alone drives every input of the block on one clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adcrat_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq, conv_start, conv_en, bip_sel;
    logic [1:0] bresp, rresp;
    logic conv_done = 1'b0, pos_above = 1'b1, int_ack = 1'b0;
    logic [9:0] conv_data = 10'h000;
    logic [7:1] trig_flags = 7'h00;
    logic [31:0] rd_val;
    logic [4:0] chan_sel;
    logic [1:0] rd_resp;
    int bad_count = 0, checks = 0, start_cnt = 0, exp_starts = 0, s;

    adcrat_top dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .conv_start(conv_start), .conv_done(conv_done),
        .conv_data(conv_data), .conv_pos_above_neg(pos_above), .trig_flags(trig_flags),
        .int_ack(int_ack), .converter_enable(conv_en), .bipolar_select(bip_sel),
        .channel_select_bits(chan_sel), .irq(irq));

    // 100 MHz clock
    always #5 clk = ~clk;
    // count conversion start pulses; a one-cycle pulse is seen at one edge only
    always @(posedge clk) begin
        if (conv_start === 1'b1) start_cnt <= start_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        bad_count++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        give_verdict();
    endtask

    // write: address and data offered together, each released when taken;
    // bready and rready stay high so back-to-back calls never toggle them
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int i;
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a);
        int i;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        rd_val = rdata;
        rd_resp = rresp;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        check(rd_val, {24'h0, e});
    endtask

    task automatic conv(input logic [9:0] d, input logic p);
        conv_data <= d; pos_above <= p; conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // software start, then a finished conversion
    task automatic start_conv(input logic [7:0] ctl, input logic [9:0] d, input logic p);
        wr(OFF_CTRL_A, ctl, RESP_OKAY);
        repeat (4) @(posedge clk);
        exp_starts++;
        check(start_cnt, exp_starts);
        conv(d, p);
    endtask

    task automatic wait_starts(input int add);
        repeat (6) @(posedge clk);
        exp_starts += add;
        check(start_cnt, exp_starts);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk(OFF_RES_LO, 8'h00);
        rd_chk(OFF_RES_HI, 8'h00);
        rd_chk(OFF_CTRL_B, 8'h00);
        rd(8'h1C);
        check(rd_val, 32'h0);
        check({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
        wr(8'h1C, 8'h55, RESP_SLVERR);
        wr(OFF_RES_LO, 8'hFF, RESP_OKAY);
        rd_chk(OFF_RES_LO, 8'h00);
        rd_chk(OFF_RES_HI, 8'h00);
        $display("test reset done");
        start_conv(8'hC0, 10'h2A5, 1'b1);
        rd_chk(OFF_RES_LO, 8'hA5);
        rd_chk(OFF_RES_HI, 8'h02);
        rd_chk(OFF_CTRL_A, 8'h90);
        check({31'h0, conv_en}, 32'h1);
        wr(OFF_INSEL, 8'h25, RESP_OKAY);
        check({27'h0, chan_sel}, 32'h5);
        rd_chk(OFF_RES_HI, 8'hA9);
        rd_chk(OFF_RES_LO, 8'h40);
        $display("test result layout done");
        // low read locks: the new result is dropped until the high read
        start_conv(8'hC0, 10'h155, 1'b1);
        rd_chk(OFF_RES_HI, 8'hA9);
        rd_chk(OFF_RES_LO, 8'h40);
        rd_chk(OFF_RES_HI, 8'hA9);
        start_conv(8'hC0, 10'h155, 1'b1);
        rd_chk(OFF_RES_LO, 8'h40);
        rd_chk(OFF_RES_HI, 8'h55);
        wr(OFF_INSEL, 8'h00, RESP_OKAY);
        $display("test lock done");
        start_conv(8'hC0, 10'h123, 1'b0);
        rd_chk(OFF_RES_LO, 8'hFF);
        rd_chk(OFF_RES_HI, 8'h03);
        wr(OFF_CTRL_B, 8'h80, RESP_OKAY);
        check({31'h0, bip_sel}, 32'h1);
        rd_chk(OFF_CTRL_B, 8'h80);
        start_conv(8'hC0, 10'h3F0, 1'b0);
        rd_chk(OFF_RES_LO, 8'hF0);
        rd_chk(OFF_RES_HI, 8'h03);
        wr(OFF_CTRL_B, 8'h00, RESP_OKAY);
        start_conv(8'hC0, 10'h1FF, 1'b1);
        rd_chk(OFF_RES_LO, 8'hFF);
        rd_chk(OFF_RES_HI, 8'h01);
        $display("test coding done");
        wr(OFF_IRQ_ST, 8'h03, RESP_OKAY);
        wr(OFF_IRQ_MSK, 8'h01, RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        start_conv(8'hC8, 10'h001, 1'b1);
        check({31'h0, irq}, 32'h1);
        wr(OFF_IRQ_ST, 8'h01, RESP_OKAY);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        start_conv(8'hC8, 10'h002, 1'b1);
        int_ack <= 1'b1;
        @(posedge clk);
        int_ack <= 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd_chk(OFF_CTRL_A, 8'h88);
        wr(OFF_IRQ_MSK, 8'h00, RESP_OKAY);
        $display("test interrupt done");
        // trigger field ignored without auto trigger enable
        wr(OFF_CTRL_A, 8'h80, RESP_OKAY);
        wr(OFF_CTRL_B, 8'h01, RESP_OKAY);
        trig_flags[1] <= 1'b1;
        wait_starts(0);
        trig_flags[1] <= 1'b0;
        wr(OFF_CTRL_A, 8'hA0, RESP_OKAY);
        for (s = 1; s < 8; s++) begin
            wr(OFF_CTRL_B, s[7:0], RESP_OKAY);
            trig_flags[s] <= 1'b1;
            wait_starts(1);
            conv(10'h000, 1'b1);
            trig_flags[s] <= 1'b0;
        end
        wr(OFF_CTRL_B, 8'h01, RESP_OKAY);
        trig_flags[2] <= 1'b1;
        wait_starts(0);
        wr(OFF_CTRL_B, 8'h02, RESP_OKAY);
        wait_starts(1);
        conv(10'h000, 1'b1);
        trig_flags[2] <= 1'b0;
        wr(OFF_CTRL_B, 8'h00, RESP_OKAY);
        wait_starts(0);
        $display("test trigger done");
        start_conv(8'hE0, 10'h011, 1'b1);
        wait_starts(1);
        conv(10'h022, 1'b1);
        wait_starts(1);
        wr(OFF_CTRL_A, 8'h00, RESP_OKAY);
        conv(10'h033, 1'b1);
        wait_starts(0);
        $display("test free running done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
